// ---- rtl/hrd_decoder.sv ----
// Host register space decoder: claims host accesses and routes them to regions
`timescale 1ns/10ps
module hrd_decoder
	import hrd_pkg::*;
(
	input  wire logic         clk_in,
	input  wire logic         reset_n_in,
	input  wire logic [31:0]  bar_base_in,
	input  wire logic         host_req_in,
	input  wire logic [31:0]  host_addr_in,
	input  wire logic         host_write_in,
	input  wire logic [3:0]   host_be_in,
	input  wire logic [31:0]  host_wdata_in,
	output wire logic         host_hit_out,
	output wire logic         host_busy_out,
	output wire logic         host_ack_out,
	output wire logic [31:0]  host_rdata_out,
	output wire logic [7:0]   region_sel_out,
	output wire logic [15:0]  region_offset_out,
	output wire logic         region_write_out,
	output wire logic [3:0]   region_be_out,
	output wire logic [31:0]  region_wdata_out,
	input  wire logic [255:0] region_rdata_in,
	input  wire logic [7:0]   region_ack_in,
	input  wire logic         sleep_mode_in,
	output wire logic         sleep_out
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	hrd_state_e  state_q;
	hrd_state_e  state_d;
	logic [7:0]  sel_q;
	logic [7:0]  strobe_q;
	logic [2:0]  idx_q;
	logic [15:0] offset_q;
	logic        write_q;
	logic [3:0]  be_q;
	logic [31:0] wdata_q;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic [4:0]  timer_q;
	logic        sleep_q;

	logic        sleep_sync_w;
	logic [15:0] offset_w;
	logic        base_match_w;
	logic        claim_w;
	logic [7:0]  hit_w;
	logic [7:0]  allowed_w;
	logic        mapped_w;
	logic [2:0]  idx_w;
	logic        region_done_w;
	logic        timeout_w;
	logic [31:0] region_word_w;

	// ------------------------------------------------------------
	// Sleep indication
	// ------------------------------------------------------------
	// Sleep state is owned by the sleep clock logic, hence the crossing
	hrd_sync2 u_sleep_sync (
		.clk_in     (clk_in),
		.reset_n_in (reset_n_in),
		.level_in   (sleep_mode_in),
		.level_out  (sleep_sync_w)
	);

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			sleep_q <= 1'b0;
		end else begin
			sleep_q <= sleep_sync_w;
		end
	end

	assign sleep_out = sleep_q;

	// ------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------
	assign offset_w     = host_addr_in[15:0];
	assign base_match_w = host_addr_in[31:16] == bar_base_in[31:16];
	assign claim_w      = host_req_in && (state_q == HRD_IDLE) && base_match_w;

	genvar g;
	generate
		for (g = 0; g < HRD_REGIONS; g++) begin : g_region
			hrd_region_match #(
				.BASE (HRD_BASE[g]),
				.LAST (HRD_LAST[g])
			) u_match (
				.offset_in (offset_w),
				.hit_out   (hit_w[g])
			);
		end
	endgenerate

	// Asleep, the clock-gated units cannot answer; only always-on stays live
	assign allowed_w = hit_w & (sleep_q ? HRD_SLEEP_MASK : HRD_ALL_MASK);
	assign mapped_w  = |allowed_w;

	always_comb begin
		idx_w = 3'h0;
		for (int i = 0; i < HRD_REGIONS; i++) begin
			if (allowed_w[i]) begin
				idx_w = 3'(i);
			end
		end
	end

	assign region_word_w = region_rdata_in[idx_q*32 +: 32];
	assign region_done_w = |(region_ack_in & sel_q);
	// A region that never answers must not hang the host bus
	assign timeout_w     = timer_q == (HRD_ACK_TIMEOUT_CYC - 5'h1);

	// ------------------------------------------------------------
	// Transaction sequencer
	// ------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		rdata_d = rdata_q;
		unique case (state_q)
			HRD_IDLE: begin
				if (claim_w && mapped_w) begin
					state_d = HRD_WAIT;
				end else if (claim_w) begin
					state_d = HRD_DONE;
					rdata_d = HRD_RDATA_RST;
				end
			end
			HRD_WAIT: begin
				if (region_done_w) begin
					state_d = HRD_DONE;
					rdata_d = write_q ? HRD_RDATA_RST : region_word_w;
				end else if (timeout_w) begin
					state_d = HRD_DONE;
					rdata_d = HRD_RDATA_RST;
				end
			end
			HRD_DONE: begin
				state_d = HRD_IDLE;
			end
			default: begin
				state_d = HRD_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			state_q <= HRD_IDLE;
			rdata_q <= HRD_RDATA_RST;
		end else begin
			state_q <= state_d;
			rdata_q <= rdata_d;
		end
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			sel_q    <= 8'h00;
			idx_q    <= 3'h0;
			offset_q <= 16'h0000;
			write_q  <= 1'b0;
			be_q     <= 4'h0;
			wdata_q  <= 32'h0000_0000;
		end else if (claim_w) begin
			sel_q    <= allowed_w;
			idx_q    <= idx_w;
			offset_q <= offset_w;
			write_q  <= host_write_in;
			be_q     <= host_be_in;
			wdata_q  <= host_wdata_in;
		end else if (state_q == HRD_DONE) begin
			sel_q    <= 8'h00;
		end
	end

	// Unmapped claims strobe nothing, so their writes go nowhere
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			strobe_q <= 8'h00;
		end else begin
			strobe_q <= claim_w ? allowed_w : 8'h00;
		end
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			timer_q <= 5'h00;
		end else if (state_q == HRD_WAIT) begin
			timer_q <= timer_q + 5'h01;
		end else begin
			timer_q <= 5'h00;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign host_hit_out      = claim_w;
	assign host_busy_out     = state_q != HRD_IDLE;
	assign host_ack_out      = state_q == HRD_DONE;
	assign host_rdata_out    = rdata_q;
	assign region_sel_out    = strobe_q;
	assign region_offset_out = offset_q;
	assign region_write_out  = write_q;
	assign region_be_out     = be_q;
	assign region_wdata_out  = wdata_q;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!reset_n_in);

	property p_route(logic [15:0] lo, logic [15:0] hi, logic [7:0] sel, logic gate);
		host_hit_out && (offset_w >= lo) && (offset_w <= hi) && (gate || !sleep_q)
			|=> region_sel_out == sel;
	endproperty

	sequence s_claim_unmapped;
		host_hit_out && !(|hit_w);
	endsequence

	sequence s_done_zero;
		host_ack_out && (host_rdata_out == 32'h0) && (region_sel_out == 8'h00);
	endsequence

	// Asleep, a claim that misses the always-on unit is finished locally
	sequence s_asleep_gated;
		host_hit_out && sleep_q && !hit_w[HRD_IDX_AON];
	endsequence

	a_route_dma_unit:
		assert property (p_route(16'h0000, 16'h07ff, 8'h01, 1'b0))
		else $error("DMA region access not routed");
	a_route_queue_ctl:
		assert property (p_route(16'h0800, 16'h0fff, 8'h02, 1'b0))
		else $error("Queue region access not routed");
	a_route_channel_acc:
		assert property (p_route(16'h1000, 16'h1fff, 8'h04, 1'b0))
		else $error("Channel region access not routed");
	a_route_always_on:
		assert property (p_route(16'h4000, 16'h4fff, 8'h08, 1'b1))
		else $error("Always-on region not reachable");
	a_route_card_info:
		assert property (p_route(16'h5000, 16'h50ff, 8'h10, 1'b0))
		else $error("Card information access not routed");
	a_route_eeprom_win:
		assert property (p_route(16'h6000, 16'h6fff, 8'h20, 1'b0))
		else $error("EEPROM window access not routed");
	a_route_protocol_ctl:
		assert property (p_route(16'h8000, 16'h87ff, 8'h40, 1'b0))
		else $error("Protocol region access not routed");
	a_route_key_table:
		assert property (p_route(16'h8800, 16'h88ff, 8'h80, 1'b0))
		else $error("Key table access not routed");
	a_claim_at_base:
		assert property (host_req_in && !host_busy_out
			&& host_addr_in[31:16] == bar_base_in[31:16] |-> host_hit_out)
		else $error("Access at base address not claimed");
	a_claim_only_base:
		assert property (host_hit_out |-> host_addr_in[31:16] == bar_base_in[31:16])
		else $error("Access outside base address claimed");
	a_sleep_high_level:
		assert property ((sleep_mode_in [*4]) |-> sleep_out)
		else $error("Sleep output not high while sleeping");
	a_sleep_low_level:
		assert property (((!sleep_mode_in) [*4]) |-> !sleep_out)
		else $error("Sleep output high while awake");
	a_unmapped_zero:
		assert property (s_claim_unmapped |=> s_done_zero)
		else $error("Unmapped access did not complete with zero");
	a_ack_bounded:
		assert property (region_sel_out != 8'h00 |-> ##[1:16] host_ack_out)
		else $error("Region access did not complete in time");
	a_sleep_gates_units:
		assert property (s_asleep_gated |=> s_done_zero)
		else $error("Clock-gated unit strobed while asleep");
	a_offset_passed:
		assert property (host_hit_out |=> region_offset_out == $past(offset_w))
		else $error("Claimed offset not passed to the region");
	a_strobe_one_hot:
		assert property ($onehot0(region_sel_out))
		else $error("More than one region strobed");
	a_ack_single_cycle:
		assert property (host_ack_out |=> !host_ack_out)
		else $error("Host acknowledge held too long");

endmodule : hrd_decoder

// ---- rtl/hrd_pkg.sv ----
// Constants and types shared by the host register space decoder
package hrd_pkg;

	// ------------------------------------------------------------
	// Region table
	// ------------------------------------------------------------
	localparam int          HRD_REGIONS = 8;
	localparam int          HRD_IDX_DMA = 0;
	localparam int          HRD_IDX_QUE = 1;
	localparam int          HRD_IDX_CHN = 2;
	localparam int          HRD_IDX_AON = 3;
	localparam int          HRD_IDX_CIS = 4;
	localparam int          HRD_IDX_EEP = 5;
	localparam int          HRD_IDX_PRO = 6;
	localparam int          HRD_IDX_KEY = 7;

	localparam logic [15:0] HRD_DMA_BASE = 16'h0000;
	localparam logic [15:0] HRD_DMA_LAST = 16'h07ff;
	localparam logic [15:0] HRD_QUE_BASE = 16'h0800;
	localparam logic [15:0] HRD_QUE_LAST = 16'h0fff;
	localparam logic [15:0] HRD_CHN_BASE = 16'h1000;
	localparam logic [15:0] HRD_CHN_LAST = 16'h1fff;
	localparam logic [15:0] HRD_AON_BASE = 16'h4000;
	localparam logic [15:0] HRD_AON_LAST = 16'h4fff;
	localparam logic [15:0] HRD_CIS_BASE = 16'h5000;
	localparam logic [15:0] HRD_CIS_LAST = 16'h50ff;
	localparam logic [15:0] HRD_EEP_BASE = 16'h6000;
	localparam logic [15:0] HRD_EEP_LAST = 16'h6fff;
	localparam logic [15:0] HRD_PRO_BASE = 16'h8000;
	localparam logic [15:0] HRD_PRO_LAST = 16'h87ff;
	localparam logic [15:0] HRD_KEY_BASE = 16'h8800;
	localparam logic [15:0] HRD_KEY_LAST = 16'h88ff;

	localparam logic [15:0] HRD_BASE [HRD_REGIONS] = '{HRD_DMA_BASE, HRD_QUE_BASE,
		HRD_CHN_BASE, HRD_AON_BASE, HRD_CIS_BASE, HRD_EEP_BASE, HRD_PRO_BASE, HRD_KEY_BASE};
	localparam logic [15:0] HRD_LAST [HRD_REGIONS] = '{HRD_DMA_LAST, HRD_QUE_LAST,
		HRD_CHN_LAST, HRD_AON_LAST, HRD_CIS_LAST, HRD_EEP_LAST, HRD_PRO_LAST, HRD_KEY_LAST};

	// Only the always-on region answers while asleep
	localparam logic [7:0]  HRD_SLEEP_MASK = 8'h08;
	localparam logic [7:0]  HRD_ALL_MASK   = 8'hff;

	// ------------------------------------------------------------
	// Reset values and timing
	// ------------------------------------------------------------
	localparam logic [31:0] HRD_RDATA_RST       = 32'h0000_0000;
	localparam logic [4:0]  HRD_ACK_TIMEOUT_CYC = 5'h10;

	typedef enum logic [1:0] {
		HRD_IDLE = 2'b00,
		HRD_WAIT = 2'b01,
		HRD_DONE = 2'b11
	} hrd_state_e;

endpackage : hrd_pkg

// ---- rtl/hrd_region_match.sv ----
// Range comparator for one register region
`timescale 1ns/10ps
module hrd_region_match #(
	parameter logic [15:0] BASE = 16'h0000,
	parameter logic [15:0] LAST = 16'h0000
) (
	input  wire logic [15:0] offset_in,
	output wire logic        hit_out
);
	assign hit_out = (offset_in >= BASE) && (offset_in <= LAST);
endmodule : hrd_region_match

// ---- rtl/hrd_sync2.sv ----
// Two flip-flop level synchroniser
`timescale 1ns/10ps
module hrd_sync2 (
	input  wire logic clk_in,
	input  wire logic reset_n_in,
	input  wire logic level_in,
	output wire logic level_out
);
	logic meta_q;
	logic sync_q;

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
		end else begin
			meta_q <= level_in;
			sync_q <= meta_q;
		end
	end

	assign level_out = sync_q;
endmodule : hrd_sync2

// ---- sim/hrd_region_model.sv ----
// Behavioural model of the eight register regions behind the decoder
`timescale 1ns/10ps
module hrd_region_model
	import hrd_pkg::*;
(
	input  wire logic         clk_in,
	input  wire logic         reset_n_in,
	input  wire logic [7:0]   sel_in,
	input  wire logic [15:0]  offset_in,
	input  wire logic [3:0]   delay_in,
	output logic      [255:0] rdata_out,
	output logic      [7:0]   ack_out
);
	// ------------------------------------------------------------
	// Pending access; delay 4'hf never answers
	// ------------------------------------------------------------
	logic [7:0]  pend_q;
	logic [3:0]  cnt_q;
	logic [15:0] off_q;
	logic [31:0] junk_q;

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			pend_q <= 8'h00;
			cnt_q  <= 4'h0;
			off_q  <= 16'h0000;
		end else if (sel_in != 8'h00) begin
			pend_q <= sel_in;
			cnt_q  <= delay_in;
			off_q  <= offset_in;
		end else if (ack_out != 8'h00) begin
			pend_q <= 8'h00;
		end else if (pend_q != 8'h00 && cnt_q != 4'hf && cnt_q != 4'h0) begin
			cnt_q <= cnt_q - 4'h1;
		end
	end

	// Idle read lanes churn so stale data never looks valid
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			junk_q <= 32'h0f0f_0f0f;
		end else begin
			junk_q <= junk_q + 32'h0101_0101;
		end
	end

	assign ack_out = (cnt_q == 4'h0) ? pend_q : 8'h00;

	always_comb begin
		for (int i = 0; i < HRD_REGIONS; i++) begin
			rdata_out[32*i+:32] = ack_out[i] ? {4'hc, 4'(i), 8'h00, off_q} : junk_q;
		end
	end
endmodule : hrd_region_model

// ---- sim/hrd_decoder_tb.sv ----
// Self-checking bench for the host register space decoder
`timescale 1ns/10ps
module hrd_decoder_tb
	import hrd_pkg::*;
;
	localparam logic [15:0] UM [6] = '{16'h2000, 16'h3ffc, 16'h5100, 16'h7000, 16'h8900, 16'hfffc};
	logic         clk = 1'b0;
	logic         rst_n = 1'b0;
	logic [31:0]  bar = 32'h5c00_0000;
	logic         req = 1'b0;
	logic [31:0]  addr = 32'h0;
	logic         wr = 1'b0;
	logic [3:0]   be = 4'h0;
	logic [31:0]  wdata = 32'h0;
	logic         hit, busy, ack, rwr, slp_out, hit_seen;
	logic         slp_in = 1'b0;
	logic [31:0]  rdata, rwd;
	logic [7:0]   sel, rack, sel_seen;
	logic [15:0]  roff;
	logic [3:0]   rbe;
	logic [3:0]   delay = 4'h0;
	logic [255:0] rrd;
	int           n_fail = 0;
	int           compares = 0;
	int           n;

	always #25 clk = ~clk;

	hrd_decoder u_hrd_decoder (.clk_in(clk), .reset_n_in(rst_n), .bar_base_in(bar),
		.host_req_in(req), .host_addr_in(addr), .host_write_in(wr), .host_be_in(be),
		.host_wdata_in(wdata), .host_hit_out(hit), .host_busy_out(busy),
		.host_ack_out(ack), .host_rdata_out(rdata), .region_sel_out(sel),
		.region_offset_out(roff), .region_write_out(rwr), .region_be_out(rbe),
		.region_wdata_out(rwd), .region_rdata_in(rrd), .region_ack_in(rack),
		.sleep_mode_in(slp_in), .sleep_out(slp_out));

	hrd_region_model u_hrd_region_model (.clk_in(clk), .reset_n_in(rst_n), .sel_in(sel),
		.offset_in(roff), .delay_in(delay), .rdata_out(rrd), .ack_out(rack));

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %s exp %h got %h", what, exp, got);
		end
	endtask : chk

	task automatic summarize();
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : summarize

	// One access; n is the cycle of the ack counted from the claim
	task automatic acc(input logic [31:0] a, input logic w, input logic poke);
		@(posedge clk);
		#2;
		req = 1'b1;
		addr = a;
		wr = w;
		be = w ? 4'ha : 4'h5;
		wdata = ~a;
		#1;
		hit_seen = hit;
		@(posedge clk);
		#2;
		req = 1'b0;
		sel_seen = sel;
		n = 0;
		if (hit_seen === 1'b1) begin
			chk("busy", 32'h1, 32'(busy));
			n = 1;
			while (ack !== 1'b1 && n < 30) begin
				@(posedge clk);
				#2;
				n++;
				req = poke && n == 4;
				#1;
				if (req === 1'b1) chk("busy hit", 32'h0, 32'(hit));
			end
		end
	endtask : acc

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_route();
		logic [15:0] o;
		for (int i = 0; i < HRD_REGIONS; i++) for (int e = 0; e < 2; e++) begin
			o = e ? (HRD_LAST[i] & 16'hfffc) : HRD_BASE[i];
			bar = e ? 32'hab12_0000 : 32'h5c00_0000;
			delay = 4'(i);
			acc({bar[31:16], o}, 1'b0, 1'b0);
			chk("sel", 32'(8'h01 << i), 32'(sel_seen));
			chk("offset", 32'(o), 32'(roff));
			chk("latency", 32'(3 + i), 32'(n));
			chk("rdata", {4'hc, 4'(i), 8'h00, o}, rdata);
		end
	endtask : t_route

	task automatic t_unmapped();
		for (int k = 0; k < 6; k++) begin
			acc({bar[31:16], UM[k]}, 1'(k), 1'b0);
			chk("um sel", 32'h0, 32'(sel_seen));
			chk("um latency", 32'd1, 32'(n));
			chk("um rdata", 32'h0, rdata);
		end
	endtask : t_unmapped

	task automatic t_write_refuse();
		delay = 4'h2;
		acc({bar[31:16], 16'h8804}, 1'b1, 1'b1);
		chk("wr sel", 32'h80, 32'(sel_seen));
		chk("wr flags", 32'h1a, {27'h0, rwr, rbe});
		chk("wr data", ~addr, rwd);
		chk("wr rdata", 32'h0, rdata);
		chk("wr latency", 32'd5, 32'(n));
		acc({~bar[31:16], 16'h0000}, 1'b0, 1'b0);
		chk("foreign hit", 32'h0, 32'(hit_seen));
		delay = 4'hf;
		acc({bar[31:16], 16'h0900}, 1'b0, 1'b0);
		chk("timeout latency", 32'(HRD_ACK_TIMEOUT_CYC) + 32'd1, 32'(n));
		chk("timeout rdata", 32'h0, rdata);
	endtask : t_write_refuse

	task automatic t_sleep();
		delay = 4'h1;
		slp_in = 1'b1;
		repeat (2) @(posedge clk);
		#2;
		chk("sleep early", 32'h0, 32'(slp_out));
		repeat (2) @(posedge clk);
		#2;
		chk("sleep on", 32'h1, 32'(slp_out));
		acc({bar[31:16], 16'h0010}, 1'b0, 1'b0);
		chk("asleep sel", 32'h0, 32'(sel_seen));
		chk("asleep rdata", 32'h0, rdata);
		acc({bar[31:16], 16'h4010}, 1'b0, 1'b0);
		chk("aon sel", 32'h08, 32'(sel_seen));
		chk("aon rdata", 32'hc300_4010, rdata);
		slp_in = 1'b0;
		repeat (4) @(posedge clk);
		#2;
		chk("sleep off", 32'h0, 32'(slp_out));
	endtask : t_sleep

	task automatic t_reset();
		delay = 4'hf;
		@(posedge clk);
		#2;
		req = 1'b1;
		addr = {bar[31:16], 16'h1000};
		@(posedge clk);
		#2;
		req = 1'b0;
		rst_n = 1'b0;
		#5;
		chk("rst state", 32'h0, {busy, ack, sel, rwr, slp_out});
		chk("rst rdata", 32'h0, rdata);
		@(posedge clk);
		#2;
		rst_n = 1'b1;
		delay = 4'h0;
		acc({bar[31:16], 16'h50fc}, 1'b0, 1'b0);
		chk("after rst", 32'hc400_50fc, rdata);
	endtask : t_reset

	initial begin
		repeat (12) @(posedge clk);
		#2;
		rst_n = 1'b1;
		chk("reset out", 32'h0, {busy, ack, sel, slp_out});
		t_route();
		t_unmapped();
		t_write_refuse();
		t_sleep();
		t_reset();
		summarize();
	end

	// Whole run needs well under a thousand cycles
	initial begin
		#200000;
		n_fail++;
		summarize();
	end
endmodule : hrd_decoder_tb
